// file: mmr_top.sv
// register window, port pins and memory selects of the memory module
// assumes the core bus and decode logic run on i_clk_sys; pins are async
module mmr_top
   import mmr_pkg::*;
#(
   parameter int IDLE_LIMIT = IDLE_CYCLES,
   parameter int OD_PINS = 4
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire mmr_bus_t i_bus,
   input wire logic i_window_sel,
   output logic [7:0] o_rdata,
   output logic o_rdata_oe,
   input wire logic [3:0][7:0] i_pin_level,
   output mmr_pin_t [3:0] o_pin,
   output logic [3:0][7:0] o_fast_slew,
   input wire mmr_pin_t [3:0] i_array_pin,
   input wire logic [3:0][7:0] i_special_oe,
   input wire logic [2:0][7:0] i_input_cells,
   output logic [15:0] o_output_cells,
   input wire logic [7:0] i_main_sel,
   input wire logic [3:0] i_boot_sel,
   input wire logic i_sram_sel,
   input wire logic [7:0] i_main_protect,
   input wire logic [3:0] i_boot_protect,
   input wire logic i_security_on,
   input wire logic i_test_port_active,
   output logic [7:0] o_main_cs,
   output logic [3:0] o_boot_cs,
   output logic o_sram_cs,
   output logic [23:0] o_ext_addr,
   output logic o_power_down
);
   initial begin
      if (IDLE_LIMIT < 2 || OD_PINS < 0 || OD_PINS > 8) begin
         $error("mmr_top: bad parameter");
      end
   end

   // ==========================================
   // reset release
   logic [1:0] rst_sync_reg;
   logic rst_n;
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // ==========================================
   // pin synchronisers: level accepted once stages two and three agree
   logic [3:0][7:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_level_reg;
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         pin_s3_reg <= '0;
         pin_level_reg <= '0;
      end else begin
         pin_s1_reg <= i_pin_level;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         for (int p = 0; p < 4; p++) begin
            for (int b = 0; b < 8; b++) begin
               if (pin_s2_reg[p][b] == pin_s3_reg[p][b]) begin
                  pin_level_reg[p][b] <= pin_s3_reg[p][b];
               end
            end
         end
      end
   end

   // ==========================================
   // bus strobes: the core's logic shares our clock, so no synchroniser
   logic wr_prev_reg;
   logic acc_ok;
   logic wr_take;
   logic [7:0] off;
   // test port owns the module while programming; core cycles ignored
   assign acc_ok = i_window_sel && !i_test_port_active;
   assign off = i_bus.addr[7:0];
   assign wr_take = acc_ok && !i_bus.wr_b && wr_prev_reg; // one write per strobe
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_prev_reg <= 1'b1;
      end else begin
         wr_prev_reg <= i_bus.wr_b;
      end
   end

   // ==========================================
   // port index of a per-port register, or 4 when none
   function automatic logic [2:0] port_of(input logic [7:0] a, input logic [7:0] oa,
                                          input logic [7:0] ob, input logic [7:0] oc,
                                          input logic [7:0] od);
      if (a == oa) begin
         port_of = 3'd0;
      end else if (a == ob) begin
         port_of = 3'd1;
      end else if (a == oc) begin
         port_of = 3'd2;
      end else if (a == od) begin
         port_of = 3'd3;
      end else begin
         port_of = 3'd4;
      end
   endfunction

   logic [2:0] out_idx, dir_idx, drv_idx;
   assign out_idx = port_of(off, OFF_OUT_A, OFF_OUT_B, OFF_OUT_C, OFF_OUT_D);
   assign dir_idx = port_of(off, OFF_DIR_A, OFF_DIR_B, OFF_DIR_C, OFF_DIR_D);
   assign drv_idx = port_of(off, OFF_DRV_A, OFF_DRV_B, OFF_DRV_C, OFF_DRV_D);

   // ==========================================
   // per-port configuration registers
   logic [3:0][7:0] out_val_reg, dir_reg, drv_reg;
   logic [1:0][7:0] mode_reg;
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         out_val_reg <= {4{RST_BYTE}};
         dir_reg <= {4{RST_BYTE}};
         drv_reg <= {4{RST_BYTE}};
         mode_reg <= {2{RST_BYTE}};
      end else if (wr_take) begin
         if (out_idx != 3'd4) begin
            out_val_reg[out_idx[1:0]] <= i_bus.wdata;
         end else if (dir_idx != 3'd4) begin
            dir_reg[dir_idx[1:0]] <= i_bus.wdata;
         end else if (drv_idx != 3'd4) begin
            drv_reg[drv_idx[1:0]] <= i_bus.wdata;
         end else if (off == OFF_MODE_A) begin
            mode_reg[0] <= i_bus.wdata;
         end else if (off == OFF_MODE_B) begin
            mode_reg[1] <= i_bus.wdata;
         end
      end
   end

   // ==========================================
   // output cells with write masks; a set mask bit keeps the cell
   logic [1:0][7:0] ocell_reg, mask_reg;
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ocell_reg <= {2{RST_BYTE}};
         mask_reg <= {2{RST_BYTE}};
      end else if (wr_take) begin
         if (off == OFF_OCELL_AB) begin
            ocell_reg[0] <= (ocell_reg[0] & mask_reg[0]) | (i_bus.wdata & ~mask_reg[0]);
         end else if (off == OFF_OCELL_BC) begin
            ocell_reg[1] <= (ocell_reg[1] & mask_reg[1]) | (i_bus.wdata & ~mask_reg[1]);
         end else if (off == OFF_MASK_AB) begin
            mask_reg[0] <= i_bus.wdata;
         end else if (off == OFF_MASK_BC) begin
            mask_reg[1] <= i_bus.wdata;
         end
      end
   end
   assign o_output_cells = {ocell_reg[1], ocell_reg[0]};

   // ==========================================
   // page, space map and power registers; protection stays read-only
   logic [7:0] page_reg, map_reg, pwr0_reg, pwr2_reg;
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         page_reg <= RST_BYTE;
         map_reg <= RST_SPACE_MAP;
         pwr0_reg <= RST_BYTE;
         pwr2_reg <= RST_BYTE;
      end else if (wr_take) begin
         if (off == OFF_PAGE) begin
            page_reg <= i_bus.wdata;
         end else if (off == OFF_SPACE_MAP) begin
            map_reg <= i_bus.wdata;
         end else if (off == OFF_PWR0) begin
            pwr0_reg <= i_bus.wdata;
         end else if (off == OFF_PWR2) begin
            pwr2_reg <= i_bus.wdata;
         end
         // writes to the protection offsets fall through untouched
      end
   end
   assign o_ext_addr = {page_reg, i_bus.addr};

   // ==========================================
   // latched address for address-out pins, caught while ale is high
   logic [15:0] lat_addr_reg;
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lat_addr_reg <= '0;
      end else if (i_bus.ale) begin
         lat_addr_reg <= i_bus.addr;
      end
   end

   // ==========================================
   // pin drivers: address out beats array, array beats core I/O
   mmr_pin_t [3:0] pin_raw;
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         for (int b = 0; b < 8; b++) begin
            if (p < 2 && mode_reg[p[0]][b]) begin
               pin_raw[p].drive[b] = lat_addr_reg[p * 8 + b];
               pin_raw[p].oe[b] = 1'b1;
            end else if (i_array_pin[p].oe[b] || i_special_oe[p][b]) begin
               pin_raw[p].drive[b] = i_array_pin[p].drive[b];
               pin_raw[p].oe[b] = 1'b1;
            end else begin
               pin_raw[p].drive[b] = out_val_reg[p][b];
               pin_raw[p].oe[b] = dir_reg[p][b];
            end
         end
      end
   end

   // open-drain on the low pins only pulls low; high pins use the bit for slew
   genvar gp, gb;
   generate
      for (gp = 0; gp < 4; gp++) begin : g_port
         for (gb = 0; gb < 8; gb++) begin : g_bit
            if (gb < OD_PINS) begin : g_od
               always_ff @(posedge i_clk_sys or negedge rst_n) begin
                  if (!rst_n) begin
                     o_pin[gp].drive[gb] <= 1'b0;
                     o_pin[gp].oe[gb] <= 1'b0;
                  end else begin
                     o_pin[gp].drive[gb] <= drv_reg[gp][gb] ? 1'b0 : pin_raw[gp].drive[gb];
                     o_pin[gp].oe[gb] <= pin_raw[gp].oe[gb] & (~drv_reg[gp][gb] | ~pin_raw[gp].drive[gb]);
                  end
               end
               assign o_fast_slew[gp][gb] = 1'b0;
            end else begin : g_cmos
               always_ff @(posedge i_clk_sys or negedge rst_n) begin
                  if (!rst_n) begin
                     o_pin[gp].drive[gb] <= 1'b0;
                     o_pin[gp].oe[gb] <= 1'b0;
                  end else begin
                     o_pin[gp].drive[gb] <= pin_raw[gp].drive[gb];
                     o_pin[gp].oe[gb] <= pin_raw[gp].oe[gb];
                  end
               end
               assign o_fast_slew[gp][gb] = drv_reg[gp][gb];
            end
         end
      end
   endgenerate

   // ==========================================
   // power management: no strobe activity for the limit enters power-down
   mmr_pm_t pm_state_reg;
   logic [31:0] idle_cnt_reg;
   logic bus_busy;
   assign bus_busy = !i_bus.rd_b || !i_bus.wr_b || !i_bus.program_store_enable_b || i_bus.ale;
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         idle_cnt_reg <= '0;
         pm_state_reg <= PM_ACTIVE;
      end else begin
         if (bus_busy) begin
            idle_cnt_reg <= '0;
         end else if (idle_cnt_reg < 32'(IDLE_LIMIT)) begin
            idle_cnt_reg <= idle_cnt_reg + 32'd1;
         end
         case (pm_state_reg)
            PM_ACTIVE: begin
               if (pwr2_reg[PWR2_FORCE_BIT] ||
                   (pwr0_reg[PWR0_AUTO_BIT] && idle_cnt_reg >= 32'(IDLE_LIMIT))) begin
                  pm_state_reg <= PM_DOWN;
               end
            end
            default: begin
               if (bus_busy && !pwr2_reg[PWR2_FORCE_BIT]) begin
                  pm_state_reg <= PM_ACTIVE;
               end
            end
         endcase
      end
   end
   assign o_power_down = (pm_state_reg == PM_DOWN);

   // ==========================================
   // memory selects: only decode array terms, gated by space map and strobes
   logic prg_cyc, dat_cyc;
   assign prg_cyc = !i_bus.program_store_enable_b && !i_test_port_active;
   assign dat_cyc = (!i_bus.rd_b || !i_bus.wr_b) && !i_test_port_active;
   // bus writes reach flash and SRAM only; array and config have no bus path
   assign o_main_cs = i_main_sel & {8{(prg_cyc && map_reg[MAP_MAIN_PRG]) ||
                                       (dat_cyc && map_reg[MAP_MAIN_DAT])}};
   assign o_boot_cs = i_boot_sel & {4{(prg_cyc && map_reg[MAP_BOOT_PRG]) ||
                                       (dat_cyc && map_reg[MAP_BOOT_DAT])}};
   assign o_sram_cs = i_sram_sel && ((prg_cyc && map_reg[MAP_SRAM_PRG]) ||
                                     (dat_cyc && map_reg[MAP_SRAM_DAT]));

   // ==========================================
   // read mux; unmapped offsets read zero
   logic [7:0] rd_mux;
   logic [2:0] in_idx, oest_idx;
   assign in_idx = port_of(off, OFF_IN_A, OFF_IN_B, OFF_IN_C, OFF_IN_D);
   assign oest_idx = port_of(off, OFF_OEST_A, OFF_OEST_B, OFF_OEST_C, OFF_OEST_D);
   always_comb begin
      if (in_idx != 3'd4) begin
         rd_mux = pin_level_reg[in_idx[1:0]];
      end else if (oest_idx != 3'd4) begin
         rd_mux = o_pin[oest_idx[1:0]].oe;
      end else if (out_idx != 3'd4) begin
         rd_mux = out_val_reg[out_idx[1:0]];
      end else if (dir_idx != 3'd4) begin
         rd_mux = dir_reg[dir_idx[1:0]];
      end else if (drv_idx != 3'd4) begin
         rd_mux = drv_reg[drv_idx[1:0]];
      end else if (off == OFF_MODE_A) begin
         rd_mux = mode_reg[0];
      end else if (off == OFF_MODE_B) begin
         rd_mux = mode_reg[1];
      end else if (off == OFF_ICELL_A) begin
         rd_mux = i_input_cells[0];
      end else if (off == OFF_ICELL_B) begin
         rd_mux = i_input_cells[1];
      end else if (off == OFF_ICELL_C) begin
         rd_mux = i_input_cells[2];
      end else if (off == OFF_OCELL_AB) begin
         rd_mux = ocell_reg[0];
      end else if (off == OFF_OCELL_BC) begin
         rd_mux = ocell_reg[1];
      end else if (off == OFF_MASK_AB) begin
         rd_mux = mask_reg[0];
      end else if (off == OFF_MASK_BC) begin
         rd_mux = mask_reg[1];
      end else if (off == OFF_PWR0) begin
         rd_mux = pwr0_reg;
      end else if (off == OFF_PWR2) begin
         rd_mux = pwr2_reg;
      end else if (off == OFF_MAIN_PROT) begin
         rd_mux = i_main_protect;
      end else if (off == OFF_BOOT_PROT) begin
         rd_mux = {i_security_on, 3'b000, i_boot_protect};
      end else if (off == OFF_PAGE) begin
         rd_mux = page_reg;
      end else if (off == OFF_SPACE_MAP) begin
         rd_mux = map_reg;
      end else begin
         rd_mux = 8'h00;
      end
   end

   // read data registered; driver enabled one edge after the strobe
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         o_rdata <= 8'h00;
         o_rdata_oe <= 1'b0;
      end else begin
         o_rdata <= (acc_ok && !i_bus.rd_b) ? rd_mux : 8'h00;
         o_rdata_oe <= acc_ok && !i_bus.rd_b;
      end
   end
endmodule

// file: mmr_pkg.sv
// package for the memory module register window
// assumes one system clock shared with the core bus logic
package mmr_pkg;
   // ==========================================
   // register offsets inside the 256-byte window
   localparam logic [7:0] OFF_IN_A = 8'h00;
   localparam logic [7:0] OFF_IN_B = 8'h01;
   localparam logic [7:0] OFF_MODE_A = 8'h02;
   localparam logic [7:0] OFF_MODE_B = 8'h03;
   localparam logic [7:0] OFF_OUT_A = 8'h04;
   localparam logic [7:0] OFF_OUT_B = 8'h05;
   localparam logic [7:0] OFF_DIR_A = 8'h06;
   localparam logic [7:0] OFF_DIR_B = 8'h07;
   localparam logic [7:0] OFF_DRV_A = 8'h08;
   localparam logic [7:0] OFF_DRV_B = 8'h09;
   localparam logic [7:0] OFF_ICELL_A = 8'h0A;
   localparam logic [7:0] OFF_ICELL_B = 8'h0B;
   localparam logic [7:0] OFF_OEST_A = 8'h0C;
   localparam logic [7:0] OFF_OEST_B = 8'h0D;
   localparam logic [7:0] OFF_IN_C = 8'h10;
   localparam logic [7:0] OFF_IN_D = 8'h11;
   localparam logic [7:0] OFF_OUT_C = 8'h12;
   localparam logic [7:0] OFF_OUT_D = 8'h13;
   localparam logic [7:0] OFF_DIR_C = 8'h14;
   localparam logic [7:0] OFF_DIR_D = 8'h15;
   localparam logic [7:0] OFF_DRV_C = 8'h16;
   localparam logic [7:0] OFF_DRV_D = 8'h17;
   localparam logic [7:0] OFF_ICELL_C = 8'h18;
   localparam logic [7:0] OFF_OEST_C = 8'h1A;
   localparam logic [7:0] OFF_OEST_D = 8'h1B;
   localparam logic [7:0] OFF_OCELL_AB = 8'h20;
   localparam logic [7:0] OFF_OCELL_BC = 8'h21;
   localparam logic [7:0] OFF_MASK_AB = 8'h22;
   localparam logic [7:0] OFF_MASK_BC = 8'h23;
   localparam logic [7:0] OFF_PWR0 = 8'hB0;
   localparam logic [7:0] OFF_PWR2 = 8'hB4;
   localparam logic [7:0] OFF_MAIN_PROT = 8'hC0;
   localparam logic [7:0] OFF_BOOT_PROT = 8'hC2;
   localparam logic [7:0] OFF_PAGE = 8'hE0;
   localparam logic [7:0] OFF_SPACE_MAP = 8'hE2;
   // ==========================================
   // reset values and field positions
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int PWR0_AUTO_BIT = 1;
   localparam int PWR2_FORCE_BIT = 0;
   localparam int MODE_ADDR_BIT = 0;
   localparam int SEC_BIT = 7;
   localparam int MAP_SRAM_PRG = 0;
   localparam int MAP_BOOT_PRG = 1;
   localparam int MAP_MAIN_PRG = 2;
   localparam int MAP_BOOT_DAT = 3;
   localparam int MAP_MAIN_DAT = 4;
   localparam int MAP_SRAM_DAT = 5;
   localparam logic [7:0] RST_SPACE_MAP = 8'h3F;
   // ==========================================
   // idle time before automatic power-down
   localparam int CLK_MHZ = 100;
   localparam int IDLE_US = 100;
   localparam int IDLE_CYCLES = IDLE_US * CLK_MHZ;
   // ==========================================
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic rd_b;
      logic wr_b;
      logic program_store_enable_b;
      logic ale;
   } mmr_bus_t;
   typedef struct packed {
      logic [7:0] drive;
      logic [7:0] oe;
   } mmr_pin_t;
   typedef enum logic [1:0] {PM_ACTIVE = 2'b00, PM_DOWN = 2'b01} mmr_pm_t;
endpackage

// file: mmr_props.sv
// checker for the memory module register window ports
// assumes one clock domain and binding onto mmr_top
module mmr_props
   import mmr_pkg::*;
#(
   parameter int IDLE_LIMIT = 8,
   parameter int OD_PINS = 4
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire mmr_bus_t i_bus,
   input wire logic i_window_sel,
   input wire logic i_test_port_active,
   input wire logic [7:0] i_main_sel,
   input wire logic [7:0] o_rdata,
   input wire logic o_rdata_oe,
   input wire logic [3:0][7:0] o_fast_slew,
   input wire logic [7:0] o_main_cs,
   input wire logic [3:0] o_boot_cs,
   input wire logic o_sram_cs,
   input wire logic [23:0] o_ext_addr,
   input wire logic o_power_down
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // helpers: low bits select open drain, so they never slew
   localparam logic [7:0] LOW_MASK = 8'((1 << OD_PINS) - 1);
   logic acc_ok;
   logic no_strobe;
   assign acc_ok = i_window_sel && !i_test_port_active;
   assign no_strobe = i_bus.program_store_enable_b && i_bus.rd_b && i_bus.wr_b;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   // ==========================================
   // read path
   a_read_answer: assert property (!i_bus.rd_b && acc_ok |=> o_rdata_oe)
      else $error("window read not answered");
   a_idle_quiet: assert property (i_bus.rd_b |=> o_rdata == 8'h00 && !o_rdata_oe)
      else $error("read data driven without read");
   a_oe_cause: assert property (o_rdata_oe |-> $past(!i_bus.rd_b && i_window_sel))
      else $error("read enable without window read");
   a_test_mute: assert property (i_test_port_active && !i_bus.rd_b |=> !o_rdata_oe)
      else $error("core read answered during test port");
   // ==========================================
   // selects, address extension, drive type, power
   a_test_no_cs: assert property (i_test_port_active |-> o_main_cs == 8'h00 && !o_sram_cs)
      else $error("select active during test port");
   a_cs_from_sel: assert property ((o_main_cs & ~i_main_sel) == 8'h00)
      else $error("main select without decode term");
   a_cs_strobe: assert property (no_strobe |-> o_main_cs == 8'h00 && o_boot_cs == 4'h0)
      else $error("select active without strobe");
   a_addr_pass: assert property (o_ext_addr[15:0] == i_bus.addr)
      else $error("low address not passed");
   a_page_load: assert property ($fell(i_bus.wr_b) && acc_ok && i_bus.addr[7:0] == OFF_PAGE
      |=> o_ext_addr[23:16] == $past(i_bus.wdata))
      else $error("page write not applied");
   a_slew_high: assert property (((o_fast_slew[0] | o_fast_slew[2] | o_fast_slew[3]) & LOW_MASK) == 8'h00)
      else $error("slew set on open drain bit");
   a_pd_force: assert property ($fell(i_bus.wr_b) && acc_ok && i_bus.addr[7:0] == OFF_PWR2
      && i_bus.wdata[PWR2_FORCE_BIT] |-> ##[1:3] o_power_down)
      else $error("forced power down not entered");
   c_read: cover property (o_rdata_oe);
   c_page: cover property ($fell(i_bus.wr_b) && acc_ok && i_bus.addr[7:0] == OFF_PAGE);
   c_down: cover property ($rose(o_power_down));
   c_test: cover property (i_test_port_active && !i_bus.rd_b);
endmodule

bind mmr_top mmr_props #(.IDLE_LIMIT(IDLE_LIMIT), .OD_PINS(OD_PINS)) u_props (
   .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_bus(i_bus), .i_window_sel(i_window_sel),
   .i_test_port_active(i_test_port_active), .i_main_sel(i_main_sel), .o_rdata(o_rdata),
   .o_rdata_oe(o_rdata_oe), .o_fast_slew(o_fast_slew), .o_main_cs(o_main_cs),
   .o_boot_cs(o_boot_cs), .o_sram_cs(o_sram_cs), .o_ext_addr(o_ext_addr), .o_power_down(o_power_down));

// file: mmr_core_model.sv
// core-side bus model: single-byte cycles into the register window
// assumes the window decode reduces to one select line
module mmr_core_model
   import mmr_pkg::*;
#(
   parameter logic [7:0] WIN_BASE = 8'h7F
) (
   input wire logic i_clk_sys,
   input wire logic [7:0] i_rdata,
   input wire logic i_rdata_oe,
   output mmr_bus_t o_bus,
   output logic o_window_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // idle bus from time zero
   initial begin
      o_bus = '{16'h0000, 8'h00, 1'b1, 1'b1, 1'b1, 1'b0};
      o_window_sel = 1'b0;
   end
   // address phase, ale high for one cycle
   task automatic addr_phase(input logic [7:0] off);
      @(negedge i_clk_sys);
      o_bus.addr = {WIN_BASE, off};
      o_bus.ale = 1'b1;
      @(negedge i_clk_sys);
      o_bus.ale = 1'b0;
      o_window_sel = 1'b1;
   endtask
   // released lines flip so stale values never pass for valid
   task automatic release_bus();
      o_bus.rd_b = 1'b1;
      o_bus.wr_b = 1'b1;
      o_window_sel = 1'b0;
      o_bus.addr = ~o_bus.addr;
      o_bus.wdata = ~o_bus.wdata;
   endtask
   task automatic wr(input logic [7:0] off, input logic [7:0] val);
      addr_phase(off);
      o_bus.wdata = val;
      o_bus.wr_b = 1'b0;
      @(negedge i_clk_sys);
      release_bus();
   endtask
   task automatic rd(input logic [7:0] off, output logic [7:0] val, output logic oe);
      addr_phase(off);
      o_bus.rd_b = 1'b0;
      @(negedge i_clk_sys);
      val = i_rdata;
      oe = i_rdata_oe;
      release_bus();
   endtask
   // program fetch strobe level
   task automatic fetch(input logic on);
      @(negedge i_clk_sys);
      o_bus.program_store_enable_b = !on;
   endtask
endmodule

// file: tb_top.sv
// self-checking bench for the memory module register window
// assumes mmr_top, mmr_core_model and mmr_props compiled first
module tb_top
   import mmr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic rst_b;
   logic test_on;
   logic [7:0] st;
   mmr_bus_t bus;
   logic win;
   logic [7:0] rdata;
   logic rdata_oe;
   mmr_pin_t [3:0] pin_o;
   logic [3:0][7:0] slew;
   logic [15:0] ocells;
   logic [7:0] main_cs;
   logic [3:0] boot_cs;
   logic sram_cs;
   logic [23:0] ext;
   logic pd;
   logic [7:0] v;
   logic oe;
   // logic array and special-function requests, idle until the priority test
   mmr_pin_t [3:0] arr = '0;
   logic [3:0][7:0] spc = '0;
   int mismatches = 0;
   int n_tests = 0;
   // ==========================================
   // rows: offset, write value, value before, value after
   localparam logic [31:0] ROWS [20] = '{
      32'h10FF5A5A, 32'h0AFFA5A5, 32'hC0FFA5A5, 32'hC2FF8585, 32'h0CFF0000,
      32'h023C003C, 32'h14F000F0, 32'h16F000F0, 32'h12960096, 32'h1AFFF0F0,
      32'h15FF00FF, 32'h170F000F, 32'h13050005, 32'h1BFFFAFA, 32'h205A005A,
      32'h22F000F0, 32'hE07E007E, 32'hE2383F38, 32'h40FF0000, 32'hB0000000};
   // status inputs all follow st, so one change moves them all
   mmr_top #(.IDLE_LIMIT(8), .OD_PINS(4)) u_mmr_top (
      .i_clk_sys(clk), .i_rst_b(rst_b), .i_bus(bus), .i_window_sel(win),
      .o_rdata(rdata), .o_rdata_oe(rdata_oe), .i_pin_level({st, ~st, st, ~st}),
      .o_pin(pin_o), .o_fast_slew(slew), .i_array_pin(arr), .i_special_oe(spc),
      .i_input_cells({st, ~st, st}), .o_output_cells(ocells), .i_main_sel(st),
      .i_boot_sel(st[3:0]), .i_sram_sel(st[0]), .i_main_protect(st), .i_boot_protect(st[3:0]),
      .i_security_on(st[7]), .i_test_port_active(test_on), .o_main_cs(main_cs),
      .o_boot_cs(boot_cs), .o_sram_cs(sram_cs), .o_ext_addr(ext), .o_power_down(pd));
   mmr_core_model u_core (.i_clk_sys(clk), .i_rdata(rdata), .i_rdata_oe(rdata_oe),
      .o_bus(bus), .o_window_sel(win));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // watchdog, far beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      finish_test();
   end
   // ==========================================
   // main sequence
   initial begin
      rst_b = 1'b0;
      test_on = 1'b0;
      st = 8'hA5;
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      repeat (5) @(negedge clk);
      for (int i = 0; i < 20; i++) begin
         u_core.rd(ROWS[i][31:24], v, oe);
         chk(v, ROWS[i][15:8]);
         u_core.wr(ROWS[i][31:24], ROWS[i][23:16]);
         u_core.rd(ROWS[i][31:24], v, oe);
         chk(v, ROWS[i][7:0]);
      end
      chk(ext[23:16], 8'h7E);
      chk(pin_o[2].oe, 8'hF0);
      chk(pin_o[2].drive & 8'hF0, 8'h90);
      chk(pin_o[3].oe, 8'hFA);
      chk(pin_o[3].drive, 8'h00);
      chk(slew[2], 8'hF0);
      u_core.rd(OFF_DIR_C, v, oe);
      chk(pin_o[0].drive & 8'h3C, 8'h14);
      u_core.wr(OFF_OCELL_AB, 8'hFF);
      chk(ocells[7:0], 8'h5F);
      // port B bit 0 to address out: latched high byte 7F puts a one there
      u_core.wr(OFF_MODE_B, 8'h01);
      @(negedge clk);
      chk(pin_o[1].oe, 8'h01);
      chk(pin_o[1].drive, 8'h01);
      // array request on bit 7 and special enable on bit 6 beat core data
      arr[3] = '{drive: 8'hC0, oe: 8'h80};
      spc[3] = 8'h40;
      repeat (2) @(negedge clk);
      chk(pin_o[3].drive, 8'hC0);
      chk(pin_o[3].oe, 8'hFA);
      arr = '0;
      spc = '0;
      repeat (2) @(negedge clk);
      chk(pin_o[3].drive, 8'h00);
      test_on = 1'b1;
      u_core.wr(OFF_OUT_C, 8'h00);
      u_core.rd(OFF_OUT_C, v, oe);
      chk(8'(oe), 8'h00);
      test_on = 1'b0;
      u_core.rd(OFF_OUT_C, v, oe);
      chk(v, 8'h96);
      // fetch with data-only map, then map restored
      u_core.fetch(1'b1);
      #1;
      chk(main_cs, 8'h00);
      u_core.wr(OFF_SPACE_MAP, 8'h3F);
      #1;
      chk(main_cs, 8'hA5);
      chk({4'h0, boot_cs}, 8'h05);
      chk(8'(sram_cs), 8'h01);
      u_core.fetch(1'b0);
      u_core.wr(OFF_PWR0, 8'h02);
      repeat (12) @(negedge clk);
      chk(8'(pd), 8'h01);
      u_core.rd(OFF_PWR0, v, oe);
      chk(v, 8'h02);
      chk(8'(pd), 8'h00);
      u_core.wr(OFF_PWR0, 8'h00);
      u_core.wr(OFF_PWR2, 8'h01);
      u_core.rd(OFF_PWR2, v, oe);
      chk(8'(pd), 8'h01);
      u_core.wr(OFF_PWR2, 8'h00);
      u_core.rd(OFF_PWR2, v, oe);
      chk(8'(pd), 8'h00);
      st = 8'h5A;
      repeat (5) @(negedge clk);
      u_core.rd(OFF_BOOT_PROT, v, oe);
      chk(v, 8'h0A);
      u_core.rd(OFF_IN_C, v, oe);
      chk(v, 8'hA5);
      // second reset in mid-run
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      repeat (5) @(negedge clk);
      u_core.rd(OFF_OUT_C, v, oe);
      chk(v, 8'h00);
      u_core.rd(OFF_SPACE_MAP, v, oe);
      chk(v, 8'h3F);
      finish_test();
   end
endmodule
